/* src/ulm_pkg.sv */
// Shared constants, carriers and helpers of the line/modem control UART block
// Assumes one 100 MHz clock and the byte-offset register port of the main module
package ulm_pkg;

   // Register byte offsets
   localparam logic [4:0] ULM_OFF_DATA   = 5'h00;
   localparam logic [4:0] ULM_OFF_IER    = 5'h04;
   localparam logic [4:0] ULM_OFF_LCR    = 5'h0c;
   localparam logic [4:0] ULM_OFF_MCR    = 5'h10;
   localparam logic [4:0] ULM_OFF_LSR    = 5'h14;

   // Line format fields
   localparam int ULM_LCR_LEN  = 0;
   localparam int ULM_LCR_STOP = 2;
   localparam int ULM_LCR_PAR  = 3;
   localparam int ULM_LCR_EVEN = 4;
   localparam int ULM_LCR_BRK  = 6;
   localparam int ULM_LCR_WIN  = 7;
   // Modem control fields
   localparam int ULM_MCR_DTR  = 0;
   localparam int ULM_MCR_RTS  = 1;
   localparam int ULM_MCR_OUTA = 2;
   localparam int ULM_MCR_OUTB = 3;
   localparam int ULM_MCR_LOOP = 4;
   // Line status fields
   localparam int ULM_LSR_RDY  = 0;
   localparam int ULM_LSR_OE   = 1;
   localparam int ULM_LSR_PERR = 2;
   localparam int ULM_LSR_FE   = 3;
   localparam int ULM_LSR_BI   = 4;
   localparam int ULM_LSR_THRE = 5;
   localparam int ULM_LSR_TEMT = 6;

   // Reset values
   localparam logic [7:0]  ULM_LCR_RST = 8'h00;
   localparam logic [4:0]  ULM_MCR_RST = 5'h00;
   localparam logic [3:0]  ULM_IER_RST = 4'h0;
   localparam logic [15:0] ULM_DIV_RST = 16'h0000;

   // Oversampling timing, in 16x ticks
   localparam logic [5:0] ULM_TICKS_BIT    = 6'h10;
   localparam logic [5:0] ULM_TICKS_HALF   = 6'h08;
   localparam logic [5:0] ULM_TICKS_STOP1  = 6'h10;
   localparam logic [5:0] ULM_TICKS_STOP15 = 6'h18;
   localparam logic [5:0] ULM_TICKS_STOP2  = 6'h20;

   typedef struct packed {
      logic [1:0] char_len_sel;
      logic       two_stop;
      logic       parity_on;
      logic       even_parity_sel;
   } ulm_fmt_s;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [31:0] wdata;
   } ulm_bus_req_s;

   typedef enum logic [2:0] {
      ULM_PH_IDLE  = 3'b000,
      ULM_PH_START = 3'b001,
      ULM_PH_DATA  = 3'b010,
      ULM_PH_PAR   = 3'b011,
      ULM_PH_STOP  = 3'b100,
      ULM_PH_HOLD  = 3'b101
   } ulm_phase_e;

   // Index of the last data bit for a length code
   function automatic logic [2:0] ulm_last_bit(input logic [1:0] len);
      ulm_last_bit = 3'h4 + {1'b0, len};
   endfunction : ulm_last_bit

   // Parity bit that completes the chosen even or odd count of ones
   function automatic logic ulm_par_bit(input logic [7:0] data, input logic [1:0] len,
                                        input logic even);
      logic [7:0] mask;
      mask = 8'hff >> (2'h3 - len);
      ulm_par_bit = (^(data & mask)) ^ ~even;
   endfunction : ulm_par_bit

endpackage : ulm_pkg

/* src/ulm_tx.sv */
// Serial character transmitter driven by 16x ticks
// Assumes start is a one-cycle pulse given only while busy is low
`timescale 1ns/1ps
`default_nettype none
module ulm_tx
   import ulm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Control
   input  wire logic       tick16,
   input  wire ulm_fmt_s   fmt,
   input  wire logic       start,
   input  wire logic [7:0] data,
   // Status and line
   output logic            busy,
   output logic            txd
);
   typedef struct packed {
      ulm_phase_e phase;
      logic [5:0] cnt;
      logic [2:0] idx;
      logic [7:0] shift;
      logic       par;
      logic       line;
   } ulm_tx_s;

   ulm_tx_s st, next_st;
   logic [5:0] stop_ticks;

   always_comb begin
      if (!fmt.two_stop) stop_ticks = ULM_TICKS_STOP1;
      else if (fmt.char_len_sel == 2'h0) stop_ticks = ULM_TICKS_STOP15;
      else stop_ticks = ULM_TICKS_STOP2;
      next_st = st;
      if (st.phase == ULM_PH_IDLE) begin
         next_st.line = 1'b1;
         if (start) begin
            next_st.shift = data;
            next_st.par   = ulm_par_bit(data, fmt.char_len_sel, fmt.even_parity_sel);
            next_st.phase = ULM_PH_START;
            next_st.cnt   = 6'h00;
            next_st.line  = 1'b0;
         end
      end else if (tick16) begin
         next_st.cnt = st.cnt + 6'h01;
         unique case (st.phase)
            ULM_PH_START: if (st.cnt == ULM_TICKS_BIT - 6'h01) begin
               next_st.phase = ULM_PH_DATA;
               next_st.cnt   = 6'h00;
               next_st.idx   = 3'h0;
               next_st.line  = st.shift[0];
            end
            ULM_PH_DATA: if (st.cnt == ULM_TICKS_BIT - 6'h01) begin
               next_st.cnt = 6'h00;
               if (st.idx == ulm_last_bit(fmt.char_len_sel)) begin
                  next_st.phase = fmt.parity_on ? ULM_PH_PAR : ULM_PH_STOP;
                  next_st.line  = fmt.parity_on ? st.par : 1'b1;
               end else begin
                  next_st.idx   = st.idx + 3'h1;
                  next_st.shift = st.shift >> 1;
                  next_st.line  = st.shift[1];
               end
            end
            ULM_PH_PAR: if (st.cnt == ULM_TICKS_BIT - 6'h01) begin
               next_st.phase = ULM_PH_STOP;
               next_st.cnt   = 6'h00;
               next_st.line  = 1'b1;
            end
            ULM_PH_STOP: if (st.cnt == stop_ticks - 6'h01) next_st.phase = ULM_PH_IDLE;
            default: next_st.phase = ULM_PH_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) st <= '{ULM_PH_IDLE, 6'h00, 3'h0, 8'h00, 1'b0, 1'b1};
      else st <= next_st;
   end

   assign busy = (st.phase != ULM_PH_IDLE);
   assign txd  = st.line;
endmodule : ulm_tx
`default_nettype wire

/* src/ulm_rx.sv */
// Serial character receiver sampling mid-bit on 16x ticks
// Assumes rxd is already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module ulm_rx
   import ulm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Control and line
   input  wire logic       tick16,
   input  wire ulm_fmt_s   fmt,
   input  wire logic       rxd,
   // Received character, valid with done
   output logic            done,
   output logic [7:0]      data,
   output logic            parity_err,
   output logic            frame_err,
   output logic            break_seen
);
   typedef struct packed {
      ulm_phase_e phase;
      logic [5:0] cnt;
      logic [2:0] idx;
      logic [7:0] shift;
      logic       par;
      logic       done;
      logic       perr;
      logic       ferr;
      logic       brk;
   } ulm_rx_s;

   ulm_rx_s st, next_st;

   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      if (st.phase == ULM_PH_IDLE) begin
         if (!rxd) begin
            next_st.phase = ULM_PH_START;
            next_st.cnt   = 6'h00;
         end
      end else if (st.phase == ULM_PH_HOLD) begin
         // Stop bit low (break or framing error): one character only, then wait for mark
         if (rxd) next_st.phase = ULM_PH_IDLE;
      end else if (tick16) begin
         next_st.cnt = st.cnt + 6'h01;
         unique case (st.phase)
            ULM_PH_START: if (st.cnt == ULM_TICKS_HALF - 6'h01) begin
               next_st.cnt   = 6'h00;
               next_st.idx   = 3'h0;
               next_st.shift = 8'h00;
               next_st.phase = rxd ? ULM_PH_IDLE : ULM_PH_DATA;
            end
            ULM_PH_DATA: if (st.cnt == ULM_TICKS_BIT - 6'h01) begin
               next_st.cnt = 6'h00;
               next_st.shift[st.idx] = rxd;
               if (st.idx == ulm_last_bit(fmt.char_len_sel)) begin
                  next_st.phase = fmt.parity_on ? ULM_PH_PAR : ULM_PH_STOP;
               end else begin
                  next_st.idx = st.idx + 3'h1;
               end
            end
            ULM_PH_PAR: if (st.cnt == ULM_TICKS_BIT - 6'h01) begin
               next_st.cnt   = 6'h00;
               next_st.par   = rxd;
               next_st.phase = ULM_PH_STOP;
            end
            ULM_PH_STOP: if (st.cnt == ULM_TICKS_BIT - 6'h01) begin
               next_st.done  = 1'b1;
               next_st.perr  = fmt.parity_on && (st.par != ulm_par_bit(st.shift,
                               fmt.char_len_sel, fmt.even_parity_sel));
               next_st.ferr  = !rxd;
               next_st.brk   = !rxd && (st.shift == 8'h00) && !(fmt.parity_on && st.par);
               next_st.phase = rxd ? ULM_PH_IDLE : ULM_PH_HOLD;
            end
            default: next_st.phase = ULM_PH_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) st <= '{ULM_PH_IDLE, 6'h00, 3'h0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      else st <= next_st;
   end

   assign done       = st.done;
   assign data       = st.shift;
   assign parity_err = st.perr;
   assign frame_err  = st.ferr;
   assign break_seen = st.brk;
endmodule : ulm_rx
`default_nettype wire

/* src/ulm_line_modem_ctrl.sv */
// Line format, modem control, divisor window, loopback and line status of the UART
// Assumes a synchronous register port with one-cycle read and write strobes
`timescale 1ns/1ps
`default_nettype none
module ulm_line_modem_ctrl
   import ulm_pkg::*;
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          resetn,
   // Register port
   input  wire ulm_bus_req_s  bus_req,
   output logic [31:0]        reg_rdata,
   // Serial lines
   input  wire logic          serial_in,
   output logic               serial_out,
   // Modem control pins
   output logic               terminal_ready_n,
   output logic               request_to_send_n,
   output logic               user_pin_a_n,
   output logic               user_pin_b_n
);

   typedef struct packed {
      logic [7:0]  line_format_reg;
      logic [4:0]  modem_output_ctrl;
      logic [3:0]  irq_enable;
      logic [7:0]  divisor_low_byte;
      logic [7:0]  divisor_high_byte;
      logic [7:0]  tx_holding_reg;
      logic        tx_hold_full;
      logic        tx_start;
      logic [7:0]  rx_holding_reg;
      logic        rx_char_waiting;
      logic        rx_overrun;
      logic        rx_parity_fault;
      logic        rx_frame_fault;
      logic        rx_break;
      logic [15:0] baud_cnt;
      logic        tick16;
      logic [31:0] rdata;
      logic        sout;
      logic [3:0]  modem_pins_n;
   } ulm_state_s;

   ulm_state_s st;
   ulm_state_s next_st;

   ulm_fmt_s    fmt;
   logic        tx_busy;
   logic        tx_line;
   logic        rx_in;
   logic        rx_done;
   logic [7:0]  rx_data;
   logic        rx_perr;
   logic        rx_ferr;
   logic        rx_brk;
   logic [15:0] divisor;
   logic        loop_on;
   logic        break_on;
   logic        window_on;
   logic        looped_line;
   logic        wr_data_off;
   logic        rd_data_off;
   logic        wr_ier_off;
   logic        rd_lsr;
   logic [7:0]  lsr_view;

   // Format fields seen by both shifters
   always_comb begin
      fmt.char_len_sel    = st.line_format_reg[ULM_LCR_LEN +: 2];
      fmt.two_stop        = st.line_format_reg[ULM_LCR_STOP];
      fmt.parity_on       = st.line_format_reg[ULM_LCR_PAR];
      fmt.even_parity_sel = st.line_format_reg[ULM_LCR_EVEN];
   end

   assign divisor   = {st.divisor_high_byte, st.divisor_low_byte};
   assign loop_on   = st.modem_output_ctrl[ULM_MCR_LOOP];
   assign break_on  = st.line_format_reg[ULM_LCR_BRK];
   assign window_on = st.line_format_reg[ULM_LCR_WIN];

   // Loopback path carries both data and break to the receiver
   assign looped_line = break_on ? 1'b0 : tx_line;
   assign rx_in       = loop_on ? looped_line : serial_in;

   // Offset decode; window steers the two lowest offsets
   assign wr_data_off = bus_req.wr && (bus_req.addr == ULM_OFF_DATA) && !window_on;
   assign rd_data_off = bus_req.rd && (bus_req.addr == ULM_OFF_DATA) && !window_on;
   assign wr_ier_off  = bus_req.wr && (bus_req.addr == ULM_OFF_IER) && !window_on;
   assign rd_lsr      = bus_req.rd && (bus_req.addr == ULM_OFF_LSR);

   always_comb begin
      lsr_view                = 8'h00;
      lsr_view[ULM_LSR_RDY]   = st.rx_char_waiting;
      lsr_view[ULM_LSR_OE]    = st.rx_overrun;
      lsr_view[ULM_LSR_PERR]  = st.rx_parity_fault;
      lsr_view[ULM_LSR_FE]    = st.rx_frame_fault;
      lsr_view[ULM_LSR_BI]    = st.rx_break;
      lsr_view[ULM_LSR_THRE]  = !st.tx_hold_full;
      lsr_view[ULM_LSR_TEMT]  = !st.tx_hold_full && !tx_busy && !st.tx_start;
   end

   always_comb begin
      next_st = st;

      // 16x tick: one pulse every divisor clocks, none while divisor is zero
      next_st.tick16 = 1'b0;
      if (divisor == 16'h0000) begin
         next_st.baud_cnt = 16'h0000;
      end else if (st.baud_cnt >= divisor - 16'h0001) begin
         next_st.baud_cnt = 16'h0000;
         next_st.tick16   = 1'b1;
      end else begin
         next_st.baud_cnt = st.baud_cnt + 16'h0001;
      end

      // Register writes
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            ULM_OFF_DATA: begin
               if (window_on) next_st.divisor_low_byte = bus_req.wdata[7:0];
            end
            ULM_OFF_IER: begin
               if (window_on) next_st.divisor_high_byte = bus_req.wdata[7:0];
            end
            ULM_OFF_LCR: next_st.line_format_reg = bus_req.wdata[7:0];
            ULM_OFF_MCR: next_st.modem_output_ctrl = bus_req.wdata[4:0];
            default: ;
         endcase
      end
      if (wr_ier_off) next_st.irq_enable = bus_req.wdata[3:0];

      // Transmit holding: accept a character, hand it to the shifter when idle
      next_st.tx_start = 1'b0;
      if (st.tx_hold_full && !tx_busy && !st.tx_start) begin
         next_st.tx_start     = 1'b1;
         next_st.tx_hold_full = 1'b0;
      end
      if (wr_data_off) begin
         next_st.tx_holding_reg = bus_req.wdata[7:0];
         next_st.tx_hold_full   = 1'b1;
      end

      // Clears from reads first, so a same-cycle event wins
      if (rd_data_off) next_st.rx_char_waiting = 1'b0;
      if (rd_lsr) begin
         next_st.rx_overrun      = 1'b0;
         next_st.rx_parity_fault = 1'b0;
         next_st.rx_frame_fault  = 1'b0;
         next_st.rx_break        = 1'b0;
      end

      // Received character, same in loopback and normal mode
      if (rx_done) begin
         next_st.rx_holding_reg  = rx_data;
         next_st.rx_char_waiting = 1'b1;
         if (st.rx_char_waiting && !rd_data_off) next_st.rx_overrun = 1'b1;
         if (rx_perr) next_st.rx_parity_fault = 1'b1;
         if (rx_ferr) next_st.rx_frame_fault = 1'b1;
         if (rx_brk) next_st.rx_break = 1'b1;
      end

      // Read data, registered; unmapped offsets read zero
      if (bus_req.rd) begin
         next_st.rdata = 32'h0000_0000;
         unique case (bus_req.addr)
            ULM_OFF_DATA: begin
               next_st.rdata[7:0] = window_on ? st.divisor_low_byte : st.rx_holding_reg;
            end
            ULM_OFF_IER: begin
               next_st.rdata[7:0] = window_on ? st.divisor_high_byte
                                              : {4'h0, st.irq_enable};
            end
            ULM_OFF_LCR: next_st.rdata[7:0] = st.line_format_reg;
            ULM_OFF_MCR: next_st.rdata[4:0] = st.modem_output_ctrl;
            ULM_OFF_LSR: next_st.rdata[7:0] = lsr_view;
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end

      // External transmit line
      if (loop_on) next_st.sout = 1'b1;
      else if (break_on) next_st.sout = 1'b0;
      else next_st.sout = tx_line;

      // Modem pins are active low
      next_st.modem_pins_n = ~st.modem_output_ctrl[ULM_MCR_OUTB:ULM_MCR_DTR];
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st                   <= '0;
         st.line_format_reg   <= ULM_LCR_RST;
         st.modem_output_ctrl <= ULM_MCR_RST;
         st.irq_enable        <= ULM_IER_RST;
         st.divisor_low_byte  <= ULM_DIV_RST[7:0];
         st.divisor_high_byte <= ULM_DIV_RST[15:8];
         st.sout              <= 1'b1;
         st.modem_pins_n      <= 4'hf;
      end else begin
         st <= next_st;
      end
   end

   ulm_tx u_tx (
      .clk    (clk),
      .resetn (resetn),
      .tick16 (st.tick16),
      .fmt    (fmt),
      .start  (st.tx_start),
      .data   (st.tx_holding_reg),
      .busy   (tx_busy),
      .txd    (tx_line)
   );

   ulm_rx u_rx (
      .clk        (clk),
      .resetn     (resetn),
      .tick16     (st.tick16),
      .fmt        (fmt),
      .rxd        (rx_in),
      .done       (rx_done),
      .data       (rx_data),
      .parity_err (rx_perr),
      .frame_err  (rx_ferr),
      .break_seen (rx_brk)
   );

   assign reg_rdata         = st.rdata;
   assign serial_out        = st.sout;
   assign terminal_ready_n  = st.modem_pins_n[ULM_MCR_DTR];
   assign request_to_send_n = st.modem_pins_n[ULM_MCR_RTS];
   assign user_pin_a_n      = st.modem_pins_n[ULM_MCR_OUTA];
   assign user_pin_b_n      = st.modem_pins_n[ULM_MCR_OUTB];

endmodule : ulm_line_modem_ctrl
`default_nettype wire

/* tb/ulm_lmc_monitor.sv */
// Checker of register port, modem pins and transmit line of the line/modem control block
// Assumes it is bound into the block and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ulm_lmc_monitor
   import ulm_pkg::*;
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // Register port
   input  wire ulm_bus_req_s bus_req,
   input  wire logic [31:0]  reg_rdata,
   // Lines and pins
   input  wire logic         serial_in,
   input  wire logic         serial_out,
   input  wire logic         terminal_ready_n,
   input  wire logic         request_to_send_n,
   input  wire logic         user_pin_a_n,
   input  wire logic         user_pin_b_n
);
   logic [7:0] lcr_q;
   logic [7:0] lo_q;
   logic [7:0] hi_q;
   logic [4:0] mcr_q;
   logic [1:0] quiet;
   logic [3:0] pins_n;
   logic       wr_ctl;
   logic       wr_win;
   assign pins_n = {user_pin_b_n, user_pin_a_n, request_to_send_n, terminal_ready_n};
   assign wr_ctl = bus_req.wr && (bus_req.addr == ULM_OFF_LCR || bus_req.addr == ULM_OFF_MCR);
   assign wr_win = bus_req.wr && lcr_q[7];
   // Shadow of software writes; quiet counts cycles since a control write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lcr_q <= '0;
         lo_q  <= '0;
         hi_q  <= '0;
         mcr_q <= '0;
         quiet <= '0;
      end else begin
         if (bus_req.wr && bus_req.addr == ULM_OFF_LCR) lcr_q <= bus_req.wdata[7:0];
         if (bus_req.wr && bus_req.addr == ULM_OFF_MCR) mcr_q <= bus_req.wdata[4:0];
         if (wr_win && bus_req.addr == ULM_OFF_DATA) lo_q <= bus_req.wdata[7:0];
         if (wr_win && bus_req.addr == ULM_OFF_IER) hi_q <= bus_req.wdata[7:0];
         quiet <= wr_ctl ? 2'd0 : (quiet == 2'd3 ? quiet : quiet + 2'd1);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_rst; $rose(resetn) |-> pins_n == 4'hf && serial_out; endproperty
   a_rst: assert property (p_rst) else $error("pins not idle after reset");
   property p_pins; quiet == 2'd3 |-> pins_n == ~mcr_q[3:0]; endproperty
   a_pins: assert property (p_pins) else $error("modem pin level wrong");
   property p_loop; quiet == 2'd3 && mcr_q[4] |-> serial_out; endproperty
   a_loop: assert property (p_loop) else $error("line not high in loopback");
   property p_brk; quiet == 2'd3 && lcr_q[6] && !mcr_q[4] |-> !serial_out; endproperty
   a_brk: assert property (p_brk) else $error("break not driven");
   property p_hold; !bus_req.rd |=> $stable(reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved without read");
   property p_unmap;
      bus_req.rd && bus_req.addr inside {5'h08, 5'h18, 5'h1c} |=> reg_rdata == 32'h0000_0000;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_lcr_rd;
      bus_req.rd && bus_req.addr == ULM_OFF_LCR
         |=> {reg_rdata[31:8], reg_rdata[7:6], reg_rdata[4:0]} == {24'h0, lcr_q[7:6], lcr_q[4:0]};
   endproperty
   a_lcr_rd: assert property (p_lcr_rd) else $error("line format read wrong");
   property p_mcr_rd; bus_req.rd && bus_req.addr == ULM_OFF_MCR |=> reg_rdata == {27'h0, mcr_q};
   endproperty
   a_mcr_rd: assert property (p_mcr_rd) else $error("modem control read wrong");
   property p_div;
      bus_req.rd && lcr_q[7] && (bus_req.addr == ULM_OFF_DATA || bus_req.addr == ULM_OFF_IER)
         |=> reg_rdata[7:0] == ($past(bus_req.addr) == ULM_OFF_IER ? hi_q : lo_q);
   endproperty
   a_div: assert property (p_div) else $error("divisor byte read wrong");
   property p_lsr_clr;
      bus_req.rd && bus_req.addr == ULM_OFF_LSR ##[1:3] bus_req.rd && bus_req.addr == ULM_OFF_LSR
         |=> reg_rdata[3:1] == 3'b000;
   endproperty
   a_lsr_clr: assert property (p_lsr_clr) else $error("status flags not cleared");
   c_loop: cover property (quiet == 2'd3 && mcr_q[4]);
   c_brk: cover property (quiet == 2'd3 && lcr_q[6] && !mcr_q[4]);
   c_div: cover property (bus_req.rd && lcr_q[7]);
endmodule : ulm_lmc_monitor
bind ulm_line_modem_ctrl ulm_lmc_monitor u_mon (
   .clk(clk), .resetn(resetn), .bus_req(bus_req), .reg_rdata(reg_rdata),
   .serial_in(serial_in), .serial_out(serial_out), .terminal_ready_n(terminal_ready_n),
   .request_to_send_n(request_to_send_n), .user_pin_a_n(user_pin_a_n),
   .user_pin_b_n(user_pin_b_n));
`default_nettype wire

/* tb/ulm_term_model.sv */
// Serial terminal on the far side: sends and samples characters
// Assumes a bit lasts BIT_CLKS clocks and the format is given by the bench
`timescale 1ns/1ps
`default_nettype none
module ulm_term_model
   import ulm_pkg::*;
#(
   parameter int BIT_CLKS = 16
)
(
   // Clock
   input  wire logic     clk,
   // Format in use
   input  wire ulm_fmt_s fmt,
   // Lines seen from the terminal
   input  wire logic     line_in,
   output logic          line_out
);
   initial line_out = 1'b1;
   // Data, parity and one stop bit
   function automatic int nbits();
      return 6 + int'(fmt.char_len_sel) + int'(fmt.parity_on);
   endfunction : nbits
   // Start bit, then the frame bits LSB first, then idle high
   task automatic send(input logic [10:0] f);
      @(negedge clk);
      line_out = 1'b0;
      repeat (BIT_CLKS) @(negedge clk);
      for (int i = 0; i < nbits(); i++) begin
         line_out = f[i];
         repeat (BIT_CLKS) @(negedge clk);
      end
      line_out = 1'b1;
      repeat (2 * BIT_CLKS) @(negedge clk);
   endtask : send
   // Samples each bit at its middle; unsampled bits read high
   task automatic get(output logic [10:0] b);
      b = '1;
      while (line_in !== 1'b0) @(negedge clk);
      repeat (BIT_CLKS / 2) @(negedge clk);
      for (int i = 0; i < nbits(); i++) begin
         repeat (BIT_CLKS) @(negedge clk);
         b[i] = line_in;
      end
   endtask : get
endmodule : ulm_term_model
`default_nettype wire

/* tb/tb_ulm_line_modem_ctrl.sv */
// Testbench of the line/modem control block: register sequences and serial traffic
// Assumes divisor 1, so one bit lasts 16 clocks
`timescale 1ns/1ps
`default_nettype none
module tb_ulm_line_modem_ctrl
   import ulm_pkg::*;
;
   logic         clk = 1'b0;
   logic         resetn;
   ulm_bus_req_s req;
   logic [31:0]  rdata;
   logic         sin;
   logic         sout;
   logic [3:0]   pins_n;
   ulm_fmt_s     fmt = '0;
   int           fails = 0;
   int           n_tests = 0;
   int           cyc = 0;
   always #5 clk = ~clk;
   ulm_line_modem_ctrl u_dut (
      .clk(clk), .resetn(resetn), .bus_req(req), .reg_rdata(rdata),
      .serial_in(sin), .serial_out(sout), .terminal_ready_n(pins_n[0]),
      .request_to_send_n(pins_n[1]), .user_pin_a_n(pins_n[2]), .user_pin_b_n(pins_n[3]));
   ulm_term_model #(.BIT_CLKS(16)) u_term (.clk(clk), .fmt(fmt), .line_in(sout), .line_out(sin));
   task automatic results();
      $display("Comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: {24'h0, d}};
      @(negedge clk);
      req = '0;
   endtask : wr
   task automatic rc(input logic [4:0] a, input logic [7:0] e, input string nm);
      @(negedge clk);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(negedge clk);
      req = '0;
      @(negedge clk);
      chk(nm, {24'h0, e}, rdata);
   endtask : rc
   function automatic logic [7:0] lcr_of(input ulm_fmt_s f);
      return {3'b000, f.even_parity_sel, f.parity_on, f.two_stop, f.char_len_sel};
   endfunction : lcr_of
   // Expected frame: data LSB first, then parity, stop bits high
   function automatic logic [10:0] frame(input logic [7:0] d, input logic bad);
      logic p;
      p = bad ^ ~fmt.even_parity_sel;
      frame = '1;
      for (int i = 0; i < 5 + int'(fmt.char_len_sel); i++) begin
         frame[i] = d[i];
         p = p ^ d[i];
      end
      if (fmt.parity_on) frame[5 + fmt.char_len_sel] = p;
   endfunction : frame
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         results();
      end
   end
   initial begin
      logic [7:0]  d;
      logic [10:0] b;
      req = '0;
      resetn = 1'b0;
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      rc(ULM_OFF_LCR, 8'h00, "lcr reset");
      rc(ULM_OFF_MCR, 8'h00, "mcr reset");
      rc(ULM_OFF_LSR, 8'h60, "lsr reset");
      rc(5'h18, 8'h00, "unmapped");
      wr(ULM_OFF_LSR, 8'hff);
      rc(ULM_OFF_LSR, 8'h60, "lsr write ignored");
      wr(ULM_OFF_IER, 8'h03);
      wr(ULM_OFF_LCR, 8'h80);
      wr(ULM_OFF_DATA, 8'h01);
      wr(ULM_OFF_IER, 8'h5a);
      rc(ULM_OFF_DATA, 8'h01, "divisor low");
      rc(ULM_OFF_IER, 8'h5a, "divisor high");
      wr(ULM_OFF_IER, 8'h00);
      wr(ULM_OFF_LCR, 8'h00);
      rc(ULM_OFF_IER, 8'h03, "enable kept");
      for (int i = 0; i < 16; i++) begin
         wr(ULM_OFF_MCR, 8'(i));
         repeat (2) @(negedge clk);
         chk("modem pins", {28'h0, ~4'(i)}, {28'h0, pins_n});
         rc(ULM_OFF_MCR, 8'(i), "mcr read");
      end
      wr(ULM_OFF_MCR, 8'h00);
      for (int i = 0; i < 8; i++) begin
         fmt = '{char_len_sel: i[1:0], two_stop: i[2], parity_on: i != 3, even_parity_sel: i[0]};
         d = 8'h96 ^ 8'(i * 37);
         wr(ULM_OFF_LCR, lcr_of(fmt));
         rc(ULM_OFF_LCR, lcr_of(fmt), "lcr read");
         fork
            u_term.get(b);
            wr(ULM_OFF_DATA, d);
         join
         chk("tx frame", {21'h0, frame(d, 1'b0)}, {21'h0, b});
         repeat (fmt.two_stop ? (fmt.char_len_sel == 2'h0 ? 13 : 21) : 5) @(negedge clk);
         rc(ULM_OFF_LSR, 8'h20, "stop busy");
         rc(ULM_OFF_LSR, 8'h60, "stop end");
         u_term.send(frame(d, 1'b0));
         rc(ULM_OFF_LSR, 8'h61, "rx ready");
         rc(ULM_OFF_DATA, d & (8'hff >> (3 - i[1:0])), "rx data");
         rc(ULM_OFF_LSR, 8'h60, "rx taken");
      end
      u_term.send(frame(8'h5a, 1'b1));
      rc(ULM_OFF_LSR, 8'h65, "parity fault");
      rc(ULM_OFF_DATA, 8'h5a, "faulty data");
      rc(ULM_OFF_LSR, 8'h60, "parity cleared");
      u_term.send(frame(8'h11, 1'b0));
      u_term.send(frame(8'h22, 1'b0));
      rc(ULM_OFF_LSR, 8'h63, "overrun");
      rc(ULM_OFF_LSR, 8'h61, "overrun cleared");
      rc(ULM_OFF_DATA, 8'h22, "newest kept");
      wr(ULM_OFF_MCR, 8'h10);
      wr(ULM_OFF_DATA, 8'h3c);
      repeat (250) @(negedge clk);
      chk("loop line", 32'h1, {31'h0, sout});
      rc(ULM_OFF_LSR, 8'h61, "loop ready");
      rc(ULM_OFF_DATA, 8'h3c, "loop data");
      wr(ULM_OFF_LCR, lcr_of(fmt) | 8'h40);
      repeat (300) @(negedge clk);
      chk("loop break line", 32'h1, {31'h0, sout});
      wr(ULM_OFF_LCR, lcr_of(fmt));
      repeat (300) @(negedge clk);
      rc(ULM_OFF_LSR, 8'h79, "loop break");
      rc(ULM_OFF_DATA, 8'h00, "break char");
      wr(ULM_OFF_MCR, 8'h00);
      wr(ULM_OFF_LCR, lcr_of(fmt) | 8'h40);
      repeat (3) @(negedge clk);
      chk("break line", 32'h0, {31'h0, sout});
      wr(ULM_OFF_LCR, lcr_of(fmt));
      repeat (3) @(negedge clk);
      chk("break over", 32'h1, {31'h0, sout});
      results();
   end
endmodule : tb_ulm_line_modem_ctrl
`default_nettype wire
